/* design/lsm_seq.sv */
// Multi-word load/store sequencer with APB register access
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/100ps
module lsm_seq
   import lsm_pkg::*;
   (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Instruction issue
   input  wire logic        iss_valid,
   input  wire logic        iss_load,
   input  wire logic [31:0] iss_addr,
   input  wire logic [7:0]  iss_reg,
   input  wire logic [2:0]  iss_opt,
   input  wire logic        iss_space,
   input  wire logic        user_mode,
   input  wire logic        pend_busy,
   output logic             pipe_hold,
   // Interrupt and trap
   input  wire logic        irq_take,
   input  wire logic        irq_return,
   output logic             prot_trap,
   // Register file
   output logic      [7:0]  rf_num,
   input  wire logic [31:0] rf_rd_data,
   input  wire logic        gpr_protected,
   output logic             rf_wr_en,
   output logic      [7:0]  rf_wr_num,
   output logic      [31:0] rf_wr_data,
   // Processor channel
   input  wire logic        burst_ok,
   input  wire logic        ch_ack,
   input  wire logic        ch_preempt,
   input  wire logic [31:0] ch_rdata,
   output logic             ch_req,
   output logic             ch_astb,
   output logic             ch_burst,
   output logic             ch_write,
   output logic      [31:0] ch_addr,
   output logic      [31:0] ch_wdata,
   output logic      [2:0]  ch_opt
   );

   // ==============================================================
   // State
   seq_state_e  state_r, state_nxt;
   logic [31:0] caddr_r, caddr_nxt;
   logic [31:0] cdata_r, cdata_nxt;
   logic [7:0]  tr_r, tr_nxt;
   logic [7:0]  cnt_r, cnt_nxt;
   logic        ml_r, ml_nxt;
   logic        cv_r, cv_nxt;
   logic        ld_r, ld_nxt;
   logic [2:0]  opt_r, opt_nxt;
   logic        need_addr_r, need_addr_nxt;
   logic        dw_r;
   logic        st_prot_r;
   logic        st_werr_r;
   logic [3:0]  kind_r;
   logic        pready_r;
   logic        pslverr_r;
   logic [31:0] prdata_r;
   logic        pipe_hold_r;
   logic        prot_trap_r;
   logic        rf_wr_en_r;
   logic [7:0]  rf_wr_num_r;
   logic [31:0] rf_wr_data_r;
   logic        ch_req_r;
   logic        ch_astb_r;
   logic        ch_burst_r;
   logic        ch_write_r;

   // ==============================================================
   // Option decode
   opt_if oi ();
   assign oi.opt              = iss_opt;
   assign oi.space_sel_bit    = iss_space;
   assign oi.width_enable_bit = dw_r;

   opt_decode u_dec (
      .o (oi.dec)
   );

   // ==============================================================
   // Event decode
   wire         running    = (state_r == S_ADDR) || (state_r == S_XFER);
   wire         can_start  = (state_r == S_IDLE) || (state_r == S_SUSP);
   wire         apb_acc    = psel && penable;
   wire         apb_stall  = pwrite && (running || pend_busy);
   wire         wr_fire    = apb_acc && pready_r && pwrite;
   wire         width_bad  = oi.width_active && (oi.is_byte || oi.is_half);
   wire         take       = iss_valid && can_start && !pend_busy && !wr_fire;
   wire         start_ok   = take && !width_bad;
   wire         resume     = irq_return && (state_r == S_SUSP) && ml_r && !take;
   wire         prot_hit   = (state_r == S_ADDR) && !irq_take && user_mode && gpr_protected;
   wire         word_done  = (state_r == S_XFER) && ch_ack;
   wire         last_word  = word_done && (cnt_r == CNT_LAST);
   wire [31:0]  addr_step  = caddr_r + ADDR_STEP;
   wire         page_cross = (addr_step[PAGE_BITS-1:0] == '0);

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   wire         hit_any = hit(paddr, OFS_COUNT) || hit(paddr, OFS_CADDR) || hit(paddr, OFS_CDATA) ||
                          hit(paddr, OFS_CCTRL) || hit(paddr, OFS_CONFIG) || hit(paddr, OFS_STATUS);
   wire [31:0]  cctrl_w = {10'h0, opt_r, ld_r, cv_r, ml_r, tr_r, cnt_r};
   wire [31:0]  status_w = {25'h0, kind_r, st_werr_r, st_prot_r, running};
   wire [31:0]  rd_mux  = hit(paddr, OFS_COUNT)  ? {24'h0, cnt_r} :
                          hit(paddr, OFS_CADDR)  ? caddr_r :
                          hit(paddr, OFS_CDATA)  ? cdata_r :
                          hit(paddr, OFS_CCTRL)  ? cctrl_w :
                          hit(paddr, OFS_CONFIG) ? {31'h0, dw_r} :
                          hit(paddr, OFS_STATUS) ? status_w : 32'h0;

   // ==============================================================
   // Sequencer next state
   always_comb begin
      state_nxt     = state_r;
      caddr_nxt     = caddr_r;
      cdata_nxt     = cdata_r;
      tr_nxt        = tr_r;
      cnt_nxt       = cnt_r;
      ml_nxt        = ml_r;
      cv_nxt        = cv_r;
      ld_nxt        = ld_r;
      opt_nxt       = opt_r;
      need_addr_nxt = need_addr_r;
      // Software restores channel state only while no sequence runs
      if (wr_fire && !running) begin
         if (hit(paddr, OFS_COUNT))
            cnt_nxt = pwdata[7:0];
         if (hit(paddr, OFS_CADDR))
            caddr_nxt = pwdata;
         if (hit(paddr, OFS_CDATA))
            cdata_nxt = pwdata;
         if (hit(paddr, OFS_CCTRL)) begin
            cnt_nxt = pwdata[CC_TR_LSB-1:0];
            tr_nxt  = pwdata[CC_ML_BIT-1:CC_TR_LSB];
            ml_nxt  = pwdata[CC_ML_BIT];
            cv_nxt  = pwdata[CC_CV_BIT];
            ld_nxt  = pwdata[CC_LD_BIT];
            opt_nxt = pwdata[CC_OPT_LSB+2:CC_OPT_LSB];
         end
      end
      unique case (state_r)
         S_IDLE, S_SUSP: begin
            if (start_ok) begin
               caddr_nxt     = iss_addr;
               tr_nxt        = iss_reg;
               ld_nxt        = iss_load;
               opt_nxt       = iss_opt;
               ml_nxt        = 1'b1;
               cv_nxt        = 1'b1;
               need_addr_nxt = 1'b1;
               state_nxt     = S_ADDR;
            end else if (resume) begin
               cv_nxt        = 1'b1;
               need_addr_nxt = 1'b1;
               state_nxt     = S_ADDR;
            end
         end
         S_ADDR: begin
            if (irq_take || prot_hit) begin
               cv_nxt    = 1'b0;
               state_nxt = S_SUSP;
            end else begin
               if (!ld_r)
                  cdata_nxt = rf_rd_data;
               state_nxt = S_XFER;
            end
         end
         S_XFER: begin
            if (last_word) begin
               ml_nxt    = 1'b0;
               cv_nxt    = 1'b0;
               state_nxt = S_IDLE;
            end else if (word_done) begin
               cnt_nxt       = 8'(cnt_r - 8'h01);
               caddr_nxt     = addr_step;
               tr_nxt        = next_reg(tr_r);
               need_addr_nxt = !burst_ok || page_cross;
               state_nxt     = S_ADDR;
            end else if (ch_preempt) begin
               need_addr_nxt = 1'b1;
               state_nxt     = S_ADDR;
            end else if (irq_take) begin
               cv_nxt    = 1'b0;
               state_nxt = S_SUSP;
            end
         end
      endcase
   end

   // ==============================================================
   // Sequencer registers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_r     <= S_IDLE;
         caddr_r     <= CADDR_RST;
         cdata_r     <= 32'h0;
         tr_r        <= TR_RST;
         cnt_r       <= COUNT_RST;
         ml_r        <= 1'b0;
         cv_r        <= 1'b0;
         ld_r        <= 1'b0;
         opt_r       <= OPT_WORD;
         need_addr_r <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         caddr_r     <= caddr_nxt;
         cdata_r     <= cdata_nxt;
         tr_r        <= tr_nxt;
         cnt_r       <= cnt_nxt;
         ml_r        <= ml_nxt;
         cv_r        <= cv_nxt;
         ld_r        <= ld_nxt;
         opt_r       <= opt_nxt;
         need_addr_r <= need_addr_nxt;
      end
   end

   // ==============================================================
   // Configuration and sticky status, set wins over write-one-clear
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dw_r      <= DW_RST;
         st_prot_r <= 1'b0;
         st_werr_r <= 1'b0;
         kind_r    <= 4'h0;
      end else begin
         if (wr_fire && hit(paddr, OFS_CONFIG))
            dw_r <= pwdata[CFG_DW_BIT];
         st_prot_r <= prot_hit || (st_prot_r && !(wr_fire && hit(paddr, OFS_STATUS) && pwdata[ST_PROT_BIT]));
         st_werr_r <= (take && width_bad) ||
                      (st_werr_r && !(wr_fire && hit(paddr, OFS_STATUS) && pwdata[ST_WERR_BIT]));
         if (take)
            kind_r <= {oi.is_rsvd, oi.is_dev, oi.is_cache, oi.is_rom};
      end
   end

   // ==============================================================
   // Registered outputs
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pready_r     <= 1'b0;
         pslverr_r    <= 1'b0;
         prdata_r     <= 32'h0;
         pipe_hold_r  <= 1'b0;
         prot_trap_r  <= 1'b0;
         rf_wr_en_r   <= 1'b0;
         rf_wr_num_r  <= TR_RST;
         rf_wr_data_r <= 32'h0;
         ch_req_r     <= 1'b0;
         ch_astb_r    <= 1'b0;
         ch_burst_r   <= 1'b0;
         ch_write_r   <= 1'b0;
      end else begin
         pready_r     <= apb_acc && !pready_r && !apb_stall;
         pslverr_r    <= apb_acc && !pready_r && !apb_stall && !hit_any;
         prdata_r     <= rd_mux;
         // Hold covers the wait for a pending access too; needs spacing
         pipe_hold_r  <= (state_nxt == S_ADDR) || (state_nxt == S_XFER) ||
                         (iss_valid && pend_busy);
         prot_trap_r  <= prot_hit;
         rf_wr_en_r   <= word_done && ld_r;
         rf_wr_num_r  <= tr_r;
         rf_wr_data_r <= ch_rdata;
         ch_req_r     <= (state_nxt == S_XFER);
         ch_astb_r    <= (state_r == S_ADDR) && (state_nxt == S_XFER) && need_addr_r;
         ch_burst_r   <= (state_nxt == S_XFER) && burst_ok && (cnt_r != CNT_LAST);
         ch_write_r   <= !ld_nxt;
      end
   end

   assign prdata     = prdata_r;
   assign pready     = pready_r;
   assign pslverr    = pslverr_r;
   assign pipe_hold  = pipe_hold_r;
   assign prot_trap  = prot_trap_r;
   assign rf_num     = tr_r;
   assign rf_wr_en   = rf_wr_en_r;
   assign rf_wr_num  = rf_wr_num_r;
   assign rf_wr_data = rf_wr_data_r;
   assign ch_req     = ch_req_r;
   assign ch_astb    = ch_astb_r;
   assign ch_burst   = ch_burst_r;
   assign ch_write   = ch_write_r;
   assign ch_addr    = caddr_r;
   assign ch_wdata   = cdata_r;
   assign ch_opt     = opt_r;

   // ==============================================================
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_mid_word;
      word_done && (cnt_r != CNT_LAST);
   endsequence
   sequence s_to_addr;
      state_r == S_ADDR;
   endsequence

   AST_COUNT_DEC: assert property (s_mid_word |=> cnt_r == 8'($past(cnt_r) - 8'h01))
      else $error("count did not drop by one after a word");
   AST_ADDR_STEP: assert property (s_mid_word |=> caddr_r == $past(caddr_r) + ADDR_STEP)
      else $error("address did not step by four");
   AST_ADDR_WRAP: assert property (s_mid_word and caddr_r == ADDR_TOP |=> caddr_r == 32'h0)
      else $error("address did not wrap to zero");
   AST_REG_WRAP: assert property (s_mid_word and tr_r == REG_GLOBAL_TOP |=> tr_r == REG_LOCAL_BASE)
      else $error("register 127 did not step to 128");
   AST_LOCAL_WRAP: assert property (s_mid_word and tr_r == REG_LOCAL_TOP |=> tr_r == REG_LOCAL_BASE)
      else $error("register 255 did not step to 128");
   AST_END: assert property (last_word |=> state_r == S_IDLE && !ml_r && !pipe_hold)
      else $error("sequence did not end at count zero");
   AST_PEND: assert property (state_r == S_IDLE && pend_busy |=> state_r != S_ADDR)
      else $error("sequence started over a pending access");
   AST_HOLD: assert property (running |-> pipe_hold)
      else $error("pipeline not held during sequence");
   AST_FRESH: assert property ((s_mid_word and !burst_ok) ##1 (s_to_addr and !irq_take && !prot_hit)
                               |=> ch_astb)
      else $error("no fresh address without burst support");
   AST_PREEMPT: assert property (state_r == S_XFER && ch_preempt && !ch_ack |=> s_to_addr ##1 ch_astb[*1]
                                 or (s_to_addr and need_addr_r))
      else $error("preempted burst did not resend address");
   AST_STALL: assert property (apb_acc && pwrite && running |=> !pready)
      else $error("register write not stalled during access");
   AST_PROT: assert property (prot_hit |=> prot_trap && state_r == S_SUSP && ml_r)
      else $error("protected register did not trap");
endmodule

/* design/lsm_seq_note.sv */
`timescale 1ns/100ps

/* design/opt_decode.sv */
// Access option field decoder
`timescale 1ns/100ps
module opt_decode
   import lsm_pkg::*;
   (
   // Option carrier
   opt_if.dec o
   );

   // ==============================================================
   // Width codes exist in every space, the rest only in data memory
   assign o.is_word      = (o.opt == OPT_WORD);
   assign o.is_byte      = (o.opt == OPT_BYTE);
   assign o.is_half      = (o.opt == OPT_HALF);
   assign o.is_rom       = (o.opt == OPT_ROM) && !o.space_sel_bit;
   assign o.is_cache     = (o.opt == OPT_CACHE) && !o.space_sel_bit;
   assign o.is_dev       = (o.opt == OPT_DEV) && !o.space_sel_bit;
   assign o.is_rsvd      = !(o.is_word || o.is_byte || o.is_half || o.is_rom || o.is_cache || o.is_dev);
   // Width codes only steer the core with the width enable set
   assign o.width_active = o.width_enable_bit && (o.is_word || o.is_byte || o.is_half);
endmodule

/* shared/lsm_pkg.sv */
// Constants, types and helpers shared by the multi-word load/store sequencer
package lsm_pkg;
   // ==============================================================
   // Register byte offsets on the APB slave
   localparam logic [7:0]  OFS_COUNT     = 8'h00;
   localparam logic [7:0]  OFS_CADDR     = 8'h04;
   localparam logic [7:0]  OFS_CDATA     = 8'h08;
   localparam logic [7:0]  OFS_CCTRL     = 8'h0c;
   localparam logic [7:0]  OFS_CONFIG    = 8'h10;
   localparam logic [7:0]  OFS_STATUS    = 8'h14;
   // ==============================================================
   // Field positions
   localparam int          CC_TR_LSB     = 8;
   localparam int          CC_ML_BIT     = 16;
   localparam int          CC_CV_BIT     = 17;
   localparam int          CC_LD_BIT     = 18;
   localparam int          CC_OPT_LSB    = 19;
   localparam int          CFG_DW_BIT    = 0;
   localparam int          ST_BUSY_BIT   = 0;
   localparam int          ST_PROT_BIT   = 1;
   localparam int          ST_WERR_BIT   = 2;
   localparam int          ST_KIND_LSB   = 3;
   // ==============================================================
   // Reset values
   localparam logic [7:0]  COUNT_RST     = 8'h00;
   localparam logic [31:0] CADDR_RST     = 32'h0;
   localparam logic [7:0]  TR_RST        = 8'h00;
   localparam logic        DW_RST        = 1'b0;
   // ==============================================================
   // Access option codes
   localparam logic [2:0]  OPT_WORD      = 3'h0;
   localparam logic [2:0]  OPT_BYTE      = 3'h1;
   localparam logic [2:0]  OPT_HALF      = 3'h2;
   localparam logic [2:0]  OPT_ROM       = 3'h4;
   localparam logic [2:0]  OPT_CACHE     = 3'h5;
   localparam logic [2:0]  OPT_DEV       = 3'h6;
   // ==============================================================
   // Stepping constants
   localparam logic [31:0] ADDR_STEP     = 32'h4;
   localparam logic [31:0] ADDR_TOP      = 32'hfffffffc;
   localparam int          PAGE_BITS     = 12;
   localparam logic [7:0]  REG_GLOBAL_TOP = 8'h7f;
   localparam logic [7:0]  REG_LOCAL_TOP = 8'hff;
   localparam logic [7:0]  REG_LOCAL_BASE = 8'h80;
   localparam logic [7:0]  CNT_LAST      = 8'h00;

   typedef enum logic [1:0] {S_IDLE, S_ADDR, S_XFER, S_SUSP} seq_state_e;

   // Local bank is circular; global bank runs into the local bank
   function automatic logic [7:0] next_reg(input logic [7:0] r);
      next_reg = (r == REG_GLOBAL_TOP || r == REG_LOCAL_TOP) ? REG_LOCAL_BASE : 8'(r + 8'h01);
   endfunction
endpackage

/* shared/opt_if.sv */
// Option-field decode carrier between sequencer and decoder
`timescale 1ns/100ps
interface opt_if;
   logic [2:0] opt;
   logic       space_sel_bit;
   logic       width_enable_bit;
   logic       is_word;
   logic       is_byte;
   logic       is_half;
   logic       is_rom;
   logic       is_cache;
   logic       is_dev;
   logic       is_rsvd;
   logic       width_active;
   modport dec (input opt, space_sel_bit, width_enable_bit,
                output is_word, is_byte, is_half, is_rom, is_cache, is_dev, is_rsvd, width_active);
   modport use_side (output opt, space_sel_bit, width_enable_bit,
                     input is_word, is_byte, is_half, is_rom, is_cache, is_dev, is_rsvd, width_active);
endinterface

/* tb/chan_mem.sv */
// Channel memory model answering word accesses after a set latency
`timescale 1ns/100ps
module chan_mem (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // Channel
   input  wire logic        ch_req,
   input  wire logic [31:0] ch_addr,
   input  wire logic [1:0]  lat,
   output logic             ch_ack,
   output logic      [31:0] ch_rdata
   );
   logic [1:0] cnt_r;
   // Data is only good with the acknowledge, so it toggles otherwise
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ch_ack   <= 1'b0;
         ch_rdata <= 32'h0;
         cnt_r    <= 2'h0;
      end else if (ch_req && !ch_ack && cnt_r >= lat) begin
         ch_ack   <= 1'b1;
         ch_rdata <= ch_addr ^ 32'h5a5a5a5a;
         cnt_r    <= 2'h0;
      end else begin
         ch_ack   <= 1'b0;
         ch_rdata <= ~ch_rdata;
         cnt_r    <= ch_req ? 2'(cnt_r + 2'h1) : 2'h0;
      end
   end
endmodule

/* tb/test_load_store_multiple_sequencer.sv */
// Self-checking bench for the multi-word load/store sequencer
`timescale 1ns/100ps
module test_load_store_multiple_sequencer;
   import lsm_pkg::*;
   logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, iss_valid = 0, iss_load = 0;
   logic iss_space = 0, pend_busy = 0, burst_ok = 0, pready, pslverr, pipe_hold, prot_trap, rf_wr_en;
   logic ch_ack, ch_req, ch_astb, ch_write, ch_burst, e;
   logic user_mode = 0, irq_return = 0, ch_preempt = 0;
   logic [7:0] paddr = 8'h0, iss_reg = 8'h0, rf_num, rf_wr_num, exp_reg, wr_reg, n_cur;
   logic [31:0] pwdata = 32'h0, iss_addr = 32'h0, prdata, rf_wr_data, ch_rdata, ch_addr, ch_wdata, exp_addr, wr_addr, q;
   logic [2:0] iss_opt = 3'h0, ch_opt;
   logic [1:0] lat = 2'h0;
   int fail_count = 0, num_checks = 0, nack, nastb, nwr, nprot;
   wire logic [31:0] rf_rd_data = {rf_num, 8'h3c, ~rf_num, 8'h96};
   // Register 0x12 is the one protected from user mode
   wire logic gpr_protected = user_mode && rf_num == 8'h12;
   always #5 clk_sys = ~clk_sys;
   lsm_seq lsm_seq_i (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .iss_valid, .iss_load, .iss_addr, .iss_reg, .iss_opt, .iss_space, .user_mode, .pend_busy, .pipe_hold,
      .irq_take(1'b0), .irq_return, .prot_trap, .rf_num, .rf_rd_data, .gpr_protected, .rf_wr_en,
      .rf_wr_num, .rf_wr_data, .burst_ok, .ch_ack, .ch_preempt, .ch_rdata, .ch_req, .ch_astb, .ch_burst,
      .ch_write, .ch_addr, .ch_wdata, .ch_opt);
   chan_mem chan_mem_i (.clk_sys, .rst, .ch_req, .ch_addr, .lat, .ch_ack, .ch_rdata);
   // ==========================================================
   // Helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] nreg(input logic [7:0] r);
      return (r == 8'h7f || r == 8'hff) ? 8'h80 : 8'(r + 8'h01);
   endfunction
   // Without preemption, a burst restarts its address only at a page edge
   function automatic int fresh(input logic [31:0] a, input int n);
      int c = 1;
      for (int i = 1; i <= n; i++) c += ((a + 32'(4 * i)) & 32'hfff) == 32'h0;
      return burst_ok ? c : n + 1;
   endfunction
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int w = 0;
      @(posedge clk_sys);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin @(posedge clk_sys); w++; end while (pready !== 1'b1 && w < 500);
      if (pready !== 1'b1) fail_count++;
      q = prdata; e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic results;
      $display("checks=%0d mismatches=%0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ==========================================================
   // Channel and register-file monitor
   always @(posedge clk_sys) if (!rst) begin
      if (ch_req) chk(32'(pipe_hold), 32'h1);
      nastb += ch_astb;
      nprot += prot_trap;
      if (ch_req && ch_ack) begin
         chk(ch_addr, exp_addr);
         chk(32'(ch_opt), 32'(iss_opt));
         chk(32'(ch_burst), 32'(burst_ok && nack != 32'(n_cur)));
         chk(32'(ch_write), 32'(!iss_load));
         if (!iss_load) chk(ch_wdata, {exp_reg, 8'h3c, ~exp_reg, 8'h96});
         exp_addr = exp_addr + 32'h4;
         exp_reg = nreg(exp_reg);
         nack++;
      end
      if (rf_wr_en) begin
         chk(32'(rf_wr_num), 32'(wr_reg));
         chk(rf_wr_data, wr_addr ^ 32'h5a5a5a5a);
         wr_addr = wr_addr + 32'h4;
         wr_reg = nreg(wr_reg);
         nwr++;
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      logic [7:0] n, r;
      logic [31:0] a;
      int w;
      void'($urandom(32'ha091e152));
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      apb(1'b0, 8'h3c, 32'h0);
      chk(q, 32'h0);
      chk(32'(e), 32'h1);
      for (int k = 0; k < 11; k++) begin
         n = k == 1 ? 8'hff : k == 2 ? 8'h01 : k == 0 ? 8'h00 : k == 3 ? 8'h10 :
             k == 10 ? 8'h03 : 8'($urandom_range(0, 40));
         a = k == 2 ? 32'hfffffffc : k == 10 ? 32'h100 : $urandom & 32'hfffffffc;
         r = k == 1 ? 8'h7e : k == 2 ? 8'hff : k == 10 ? 8'h10 : 8'($urandom);
         apb(1'b1, OFS_COUNT, {24'h0, n});
         apb(1'b0, OFS_COUNT, 32'h0);
         chk(q, {24'h0, n});
         exp_addr = a; wr_addr = a; exp_reg = r; wr_reg = r;
         nack = 0; nastb = 0; nwr = 0; nprot = 0; n_cur = n;
         @(posedge clk_sys);
         burst_ok <= k[0] || k == 10; lat <= k == 10 ? 2'h3 : 2'($urandom); user_mode <= (k == 10);
         pend_busy <= 1'($urandom); iss_load <= 1'($urandom);
         iss_valid <= 1'b1; iss_addr <= a; iss_reg <= r; iss_opt <= 3'($urandom); iss_space <= 1'($urandom);
         repeat (3) @(posedge clk_sys);
         if (pend_busy) chk(32'(ch_req), 32'h0);
         pend_busy <= 1'b0;
         w = 0;
         while (ch_req !== 1'b1 && w < 100) begin @(posedge clk_sys); w++; end
         if (w >= 100) fail_count++;
         iss_valid <= 1'b0;
         // A count write during the sequence may only complete after it
         if (k == 3) begin
            apb(1'b1, OFS_COUNT, 32'h0);
            chk(32'(pipe_hold), 32'h0);
         end
         w = 0;
         while (pipe_hold !== 1'b0 && w < 3000) begin @(posedge clk_sys); w++; end
         if (w >= 3000) fail_count++;
         repeat (2) @(posedge clk_sys);
         // Trap on the protected third register, then resume into a preempted burst
         if (k == 10) begin
            chk(nack, 32'h2);
            chk(nprot, 32'h1);
            apb(1'b0, OFS_CADDR, 32'h0);
            chk(q, a + 32'h8);
            apb(1'b0, OFS_CCTRL, 32'h0);
            chk(q, {10'h0, iss_opt, iss_load, 2'b01, 8'h12, 8'h01});
            user_mode <= 1'b0;
            irq_return <= 1'b1;
            @(posedge clk_sys);
            irq_return <= 1'b0;
            w = 0;
            while (ch_req !== 1'b1 && w < 100) begin @(posedge clk_sys); w++; end
            if (w >= 100) fail_count++;
            ch_preempt <= 1'b1;
            @(posedge clk_sys);
            ch_preempt <= 1'b0;
            w = 0;
            while (pipe_hold !== 1'b0 && w < 3000) begin @(posedge clk_sys); w++; end
            if (w >= 3000) fail_count++;
            repeat (2) @(posedge clk_sys);
         end
         chk(nack, n + 1);
         chk(nwr, iss_load ? n + 1 : 0);
         chk(nastb, fresh(a, n) + (k == 10 ? 2 : 0));
      end
      // Byte option with the width enable set is refused and flagged
      apb(1'b1, OFS_CONFIG, 32'h1);
      nack = 0;
      iss_opt <= OPT_BYTE;
      iss_valid <= 1'b1;
      repeat (4) @(posedge clk_sys);
      iss_valid <= 1'b0;
      chk(32'(pipe_hold), 32'h0);
      chk(nack, 32'h0);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(q, 32'((1 << ST_WERR_BIT) | (1 << ST_PROT_BIT)));
      apb(1'b1, OFS_STATUS, 32'h6);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(q, 32'h0);
      results();
   end
   initial begin
      #300000;
      fail_count++;
      results();
   end
endmodule
